// [console_terminal_mode_control_test.sv]
`timescale 1ns/1ns
module console_terminal_mode_control_test;
  typedef struct packed {logic [5:0] code; logic [15:0] exp;} ctm_row_t;
  logic sys_clk, rst, reg_wr, reg_rd, console_mounted, start_input, power_restore;
  logic retained_terminal, press, busy, key_valid, terminal_active, program_executing;
  logic mem_write_allowed, force_allowed, edit_allowed, shift_armed, no_message, edit_key_pulse;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, retained_key_word, key_word, rd_v, e;
  logic [5:0] key_code, p_code;
  logic [1:0] mode_switch;
  logic [2:0] exec_mode, screen;
  logic [7:0] disp_char;
  logic [4:0] disp_addr;
  int n_mismatch, total_checks, cyc, i, n_edit;
  ctm_row_t rows[17];
  ctm_console dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .key_valid, .key_code, .console_mounted, .mode_switch, .start_input, .power_restore,
    .retained_key_word, .retained_terminal, .terminal_active, .exec_mode, .screen,
    .program_executing, .mem_write_allowed, .force_allowed, .edit_allowed, .shift_armed,
    .no_message, .key_word, .disp_char, .disp_addr, .edit_key_pulse);
  ctm_keypad_model kp_u (.sys_clk, .press, .code(p_code), .key_valid, .key_code, .busy);
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  always @(posedge sys_clk) begin
    if (edit_key_pulse === 1'h1) n_edit <= n_edit + 1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    idle(3);
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    rd_v = reg_rdata;
  endtask
  task automatic key(input logic [5:0] c);
    int t;
    @(posedge sys_clk);
    press <= 1'h1;
    p_code <= c;
    @(posedge sys_clk);
    press <= 1'h0;
    idle(2);
    for (t = 0; t < 50 && busy === 1'h1; t++) @(posedge sys_clk);
    idle(3);
  endtask
  // each ctrl write also rewrites cancel and startup, so startup goes last
  task automatic pwr(input logic [15:0] ctl, input logic t, input logic [15:0] kw);
    wr(ctm_pkg::REG_CTRL, ctl);
    @(posedge sys_clk);
    retained_terminal <= t;
    retained_key_word <= kw;
    power_restore <= 1'h1;
    @(posedge sys_clk);
    power_restore <= 1'h0;
    idle(4);
  endtask
  initial begin
    {rst, n_mismatch, total_checks} = {1'h1, 64'h0};
    {reg_wr, reg_rd, power_restore, retained_terminal, press, start_input} = 6'h00;
    {reg_addr, reg_wdata, retained_key_word, p_code, mode_switch} = 44'h0;
    console_mounted = 1'h1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    idle(4);
    chk(terminal_active, 1'h0);
    chk(exec_mode, ctm_pkg::EXEC_PROGRAM);
    chk(no_message, 1'h1);
    rd(4'hF);
    chk(rd_v, 16'h0000);
    rd(ctm_pkg::REG_KEY_WORD);
    chk(rd_v, ctm_pkg::KEY_WORD_RST);
    key(ctm_pkg::KEY_SHIFT);
    chk(shift_armed, 1'h1);
    key(6'h03);
    chk(shift_armed, 1'h0);
    chk(key_word, 16'h0000);
    chk(screen, ctm_pkg::SCR_OTHER);
    key(ctm_pkg::KEY_MODE_TOGGLE);
    chk(terminal_active, 1'h0);
    repeat (ctm_pkg::CLEAR_PRESSES) key(ctm_pkg::KEY_CLEAR);
    chk(screen, ctm_pkg::SCR_MODE);
    key(ctm_pkg::KEY_MODE_TOGGLE);
    chk(terminal_active, 1'h1);
    chk(no_message, 1'h1);
    e = 16'h0000;
    for (i = 0; i < 16; i++) begin
      e = e | (16'h0001 << (15 - i));
      rows[i] = {6'(15 - i), e};
    end
    rows[16] = {6'h0F, 16'hFFFF};
    for (i = 0; i < 17; i++) begin
      key(rows[i].code);
      chk(key_word, rows[i].exp);
    end
    mode_switch <= 2'h2;
    start_input <= 1'h1;
    key(ctm_pkg::KEY_EDIT);
    chk(exec_mode, ctm_pkg::EXEC_PROGRAM);
    chk(16'(n_edit), 16'h0000);
    key(ctm_pkg::KEY_MODE_TOGGLE);
    chk(terminal_active, 1'h0);
    chk(screen, ctm_pkg::SCR_MODE);
    chk(key_word, 16'hFFFF);
    idle(6);
    chk(exec_mode, ctm_pkg::EXEC_RUN);
    chk({program_executing, mem_write_allowed}, 2'h2);
    mode_switch <= 2'h1;
    idle(6);
    chk({program_executing, force_allowed}, 2'h3);
    mode_switch <= 2'h0;
    idle(6);
    chk({program_executing, edit_allowed}, 2'h1);
    for (i = 0; i < ctm_pkg::SHORT_MSG_LEN; i++) wr(ctm_pkg::REG_MSG_DATA, 16'h0041 + 16'(i));
    wr(ctm_pkg::REG_CTRL, 16'h0010);
    chk(no_message, 1'h0);
    mode_switch <= 2'h2;
    idle(6);
    chk(no_message, 1'h0);
    mode_switch <= 2'h0;
    console_mounted <= 1'h0;
    wr(ctm_pkg::REG_MSG_CTRL, ctm_pkg::EMUL_TOGGLE_CODE);
    wr(ctm_pkg::REG_CTRL, 16'h0008);
    chk(terminal_active, 1'h0);
    console_mounted <= 1'h1;
    idle(2);
    wr(ctm_pkg::REG_CTRL, 16'h0008);
    chk(terminal_active, 1'h1);
    for (i = 0; i < 20; i++) begin
      idle(1);
      chk(16'(disp_char), 16'h0041 + 16'(disp_addr));
      chk(16'(disp_addr < 5'h10), 16'h0001);
    end
    wr(ctm_pkg::REG_CTRL, 16'h0008);
    chk(terminal_active, 1'h0);
    wr(ctm_pkg::REG_CTRL, 16'h0008);
    chk(terminal_active, 1'h1);
    chk(exec_mode, ctm_pkg::EXEC_PROGRAM);
    wr(ctm_pkg::REG_CTRL, 16'h0001);
    chk(key_word, 16'h0000);
    key(6'h02);
    chk(key_word, 16'h0000);
    wr(ctm_pkg::REG_CTRL, 16'h0000);
    key(6'h02);
    chk(key_word, 16'h0004);
    wr(ctm_pkg::REG_KEY_WORD, 16'h1230);
    rd(ctm_pkg::REG_KEY_WORD);
    chk(rd_v, 16'h1230);
    pwr(16'h0002, 1'h1, 16'hA5A5);
    chk(terminal_active, 1'h1);
    chk(key_word, 16'hA5A5);
    pwr(16'h0004, 1'h0, 16'h5A5A);
    chk(terminal_active, 1'h1);
    pwr(16'h0000, 1'h1, 16'h5A5A);
    chk(terminal_active, 1'h0);
    chk(screen, ctm_pkg::SCR_PASSWORD);
    key(ctm_pkg::KEY_MODE_TOGGLE);
    chk(terminal_active, 1'h1);
    key(ctm_pkg::KEY_MODE_TOGGLE);
    key(ctm_pkg::KEY_EDIT);
    chk(16'(n_edit), 16'h0001);
    end_of_test();
  end
endmodule

// [ctm_console.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - mode toggle enters terminal only from password or mode screen; else clear first
// - toggle in terminal returns to editing and shows execution mode screen
// - terminal ignores editing keys and the mode selector switch
// - console state and execution mode are independent
// - program emulation code 4021 means clear then mode toggle
// - emulation does nothing when no console is mounted
// - power-up enters terminal per startup setting or resumed state
// - messages are short 16 or long 32 characters
// - entering terminal shows the latest message
// - no message yet shows a no-message indication
// - latest message survives execution mode changes
// - hex key n in terminal sets key word bit n
// - keys set bits only while cancel bit is clear
// - cancel bit clears the whole key word and blocks keys
// - key word kept across terminal changes and power cycles
// - clear key aborts operation; two presses blank display
// - shift modifies only the next key
// - run with start executes; memory writes rejected
// - monitor runs like run but allows forcing and value changes
// - program mode halts execution and allows editing
module ctm_console (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic key_valid,
  input wire logic [5:0] key_code,
  input wire logic console_mounted,
  input wire logic [1:0] mode_switch,
  input wire logic start_input,
  input wire logic power_restore,
  input wire logic [15:0] retained_key_word,
  input wire logic retained_terminal,
  output logic terminal_active,
  output logic [2:0] exec_mode,
  output logic [2:0] screen,
  output logic program_executing,
  output logic mem_write_allowed,
  output logic force_allowed,
  output logic edit_allowed,
  output logic shift_armed,
  output logic no_message,
  output logic [15:0] key_word,
  output logic [7:0] disp_char,
  output logic [4:0] disp_addr,
  output logic edit_key_pulse
);
  ctm_msg_if msg ();
  ctm_msg_mem #(.DEPTH(ctm_pkg::LONG_MSG_LEN)) u_mem (
    .sys_clk(sys_clk),
    .bus(msg)
  );

  logic [1:0] sync_valid_r;
  logic [5:0] sync_code0_r;
  logic [5:0] sync_code1_r;
  logic [1:0] sync_mnt_r;
  logic [1:0] sync_sw0_r;
  logic [1:0] sync_sw1_r;
  logic [1:0] sync_start_r;
  logic key_prev_r;
  logic key_stb;
  logic mounted;

  // key, mount, selector and start pins pass two flops; the code has its own two-flop chain, read when the strobe fires
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_valid_r <= 2'h0;
      sync_code0_r <= 6'h00;
      sync_code1_r <= 6'h00;
      sync_mnt_r <= 2'h0;
      sync_sw0_r <= 2'h0;
      sync_sw1_r <= 2'h0;
      sync_start_r <= 2'h0;
      key_prev_r <= 1'b0;
    end else begin
      sync_valid_r <= {sync_valid_r[0], key_valid};
      sync_code0_r <= key_code;
      sync_code1_r <= sync_code0_r;
      sync_mnt_r <= {sync_mnt_r[0], console_mounted};
      sync_sw0_r <= mode_switch;
      sync_sw1_r <= sync_sw0_r;
      sync_start_r <= {sync_start_r[0], start_input};
      key_prev_r <= sync_valid_r[1];
    end
  end
  assign key_stb = sync_valid_r[1] && !key_prev_r;
  assign mounted = sync_mnt_r[1];

  // software registers
  logic [15:0] key_word_r;
  logic cancel_r;
  logic [1:0] startup_r;
  logic msg_long_r;
  logic [4:0] msg_wptr_r;
  logic msg_valid_r;
  logic msg_len_long_r;
  logic wr_ctrl;
  logic emul_req;
  logic msg_commit;

  assign wr_ctrl = reg_wr && reg_addr == ctm_pkg::REG_CTRL;
  assign emul_req = wr_ctrl && reg_wdata[ctm_pkg::CTRL_EMUL];
  assign msg_commit = wr_ctrl && reg_wdata[ctm_pkg::CTRL_MSG_COMMIT];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cancel_r <= 1'b0;
      startup_r <= ctm_pkg::STARTUP_SWITCH;
      msg_long_r <= 1'b0;
    end else if (wr_ctrl) begin
      cancel_r <= reg_wdata[ctm_pkg::CTRL_CANCEL];
      startup_r <= reg_wdata[ctm_pkg::CTRL_STARTUP_LO +: 2];
      msg_long_r <= reg_wdata[ctm_pkg::CTRL_MSG_LONG];
    end
  end

  // emulation operand must be written before the emulate strobe that uses it
  logic [15:0] emul_code_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      emul_code_r <= 16'h0000;
    end else if (reg_wr && reg_addr == ctm_pkg::REG_MSG_CTRL) begin
      emul_code_r <= reg_wdata;
    end
  end

  // console state machine
  ctm_pkg::ctm_con_t con_r;
  ctm_pkg::ctm_scr_t scr_r;
  logic shift_r;
  logic [1:0] clr_cnt_r;
  logic term_key;
  logic toggle_key;
  logic emul_toggle;
  logic boot_pending_r;

  assign term_key = key_stb && con_r == ctm_pkg::CON_TERMINAL;
  assign toggle_key = key_stb && sync_code1_r == ctm_pkg::KEY_MODE_TOGGLE;
  // clear pair skips the screen check so the toggle lands from any screen; entering terminal leaves the screen as it was
  assign emul_toggle = emul_req && mounted &&
    emul_code_r[15:8] == ctm_pkg::EMUL_CLEAR_PAIR &&
    emul_code_r[7:0] == ctm_pkg::EMUL_TOGGLE_PAIR;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      con_r <= ctm_pkg::CON_EDIT;
      scr_r <= ctm_pkg::SCR_PASSWORD;
      boot_pending_r <= 1'b1;
      clr_cnt_r <= 2'h0;
    end else if (boot_pending_r || power_restore) begin
      boot_pending_r <= 1'b0;
      scr_r <= ctm_pkg::SCR_PASSWORD;
      if (startup_r == ctm_pkg::STARTUP_TERMINAL ||
          (startup_r == ctm_pkg::STARTUP_RESUME && retained_terminal)) begin
        con_r <= ctm_pkg::CON_TERMINAL;
      end else begin
        con_r <= ctm_pkg::CON_EDIT;
      end
    end else if (emul_toggle) begin
      if (con_r == ctm_pkg::CON_TERMINAL) begin
        con_r <= ctm_pkg::CON_EDIT;
        scr_r <= ctm_pkg::SCR_MODE;
      end else begin
        con_r <= ctm_pkg::CON_TERMINAL;
      end
    end else if (key_stb) begin
      case (con_r)
        ctm_pkg::CON_TERMINAL: begin
          if (toggle_key) begin
            con_r <= ctm_pkg::CON_EDIT;
            scr_r <= ctm_pkg::SCR_MODE;
          end
        end
        ctm_pkg::CON_EDIT: begin
          if (toggle_key && scr_r != ctm_pkg::SCR_OTHER) begin
            con_r <= ctm_pkg::CON_TERMINAL;
          end else if (sync_code1_r == ctm_pkg::KEY_CLEAR) begin
            // two presses fully blank; the first only aborts
            if (clr_cnt_r == 2'(ctm_pkg::CLEAR_PRESSES - 1)) begin
              scr_r <= ctm_pkg::SCR_MODE;
              clr_cnt_r <= 2'h0;
            end else begin
              clr_cnt_r <= clr_cnt_r + 2'h1;
            end
          end else if (!toggle_key) begin
            scr_r <= ctm_pkg::SCR_OTHER;
            clr_cnt_r <= 2'h0;
          end
        end
        default: begin
          con_r <= ctm_pkg::CON_EDIT;
        end
      endcase
    end
  end

  // shift latch lives only for the next editing key
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_r <= 1'b0;
    end else if (key_stb && con_r == ctm_pkg::CON_EDIT) begin
      shift_r <= sync_code1_r == ctm_pkg::KEY_SHIFT && !shift_r;
    end
  end

  // key word: sticky bits, cancel wins over keys, program write wins over keys
  logic wr_key;
  assign wr_key = reg_wr && reg_addr == ctm_pkg::REG_KEY_WORD;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      key_word_r <= ctm_pkg::KEY_WORD_RST;
    end else if (power_restore) begin
      key_word_r <= retained_key_word;
    end else if (cancel_r) begin
      key_word_r <= 16'h0000;
    end else if (wr_key) begin
      key_word_r <= reg_wdata;
    end else if (term_key && sync_code1_r[5:4] == 2'h0) begin
      key_word_r[sync_code1_r[3:0]] <= 1'b1;
    end
  end

  // execution mode follows the selector only in editing state
  ctm_pkg::ctm_exec_t exec_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      exec_r <= ctm_pkg::EXEC_PROGRAM;
    end else if (con_r == ctm_pkg::CON_EDIT) begin
      case (sync_sw1_r)
        2'h1: exec_r <= ctm_pkg::EXEC_MONITOR;
        2'h2: exec_r <= ctm_pkg::EXEC_RUN;
        default: exec_r <= ctm_pkg::EXEC_PROGRAM;
      endcase
    end
  end

  // message capture: program writes chars, commit marks it current
  logic wr_msg;
  assign wr_msg = reg_wr && reg_addr == ctm_pkg::REG_MSG_DATA;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      msg_wptr_r <= 5'h00;
      msg_valid_r <= 1'b0;
      msg_len_long_r <= 1'b0;
    end else if (msg_commit) begin
      msg_wptr_r <= 5'h00;
      msg_valid_r <= 1'b1;
      msg_len_long_r <= reg_wdata[ctm_pkg::CTRL_MSG_LONG];
    end else if (wr_msg) begin
      msg_wptr_r <= msg_wptr_r + 5'h01;
    end
  end
  assign msg.we = wr_msg;
  assign msg.waddr = msg_wptr_r;
  assign msg.wdata = reg_wdata[7:0];

  // display scan walks the latest message while terminal is active
  logic [4:0] scan_r;
  logic [4:0] scan_last;
  assign scan_last = msg_len_long_r ? 5'(ctm_pkg::LONG_MSG_LEN - 1) :
    5'(ctm_pkg::SHORT_MSG_LEN - 1);
  always_ff @(posedge sys_clk) begin
    if (rst || con_r != ctm_pkg::CON_TERMINAL) begin
      scan_r <= 5'h00;
    end else if (scan_r == scan_last) begin
      scan_r <= 5'h00;
    end else begin
      scan_r <= scan_r + 5'h01;
    end
  end
  assign msg.raddr = scan_r;

  // read data lag the scan address by one cycle; the delayed copy keeps them paired
  logic [4:0] scan_d_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scan_d_r <= 5'h00;
    end else begin
      scan_d_r <= scan_r;
    end
  end

  // outputs
  logic exec_run;
  assign exec_run = exec_r == ctm_pkg::EXEC_RUN || exec_r == ctm_pkg::EXEC_MONITOR;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      terminal_active <= 1'b0;
      exec_mode <= 3'h1;
      screen <= 3'h1;
      program_executing <= 1'b0;
      mem_write_allowed <= 1'b0;
      force_allowed <= 1'b0;
      edit_allowed <= 1'b0;
      shift_armed <= 1'b0;
      no_message <= 1'b1;
      key_word <= 16'h0000;
      disp_char <= 8'h00;
      disp_addr <= 5'h00;
      edit_key_pulse <= 1'b0;
    end else begin
      terminal_active <= con_r == ctm_pkg::CON_TERMINAL;
      exec_mode <= exec_r;
      screen <= scr_r;
      program_executing <= exec_run && sync_start_r[1];
      mem_write_allowed <= exec_r != ctm_pkg::EXEC_RUN;
      force_allowed <= exec_r == ctm_pkg::EXEC_MONITOR;
      edit_allowed <= exec_r == ctm_pkg::EXEC_PROGRAM;
      shift_armed <= shift_r;
      no_message <= !msg_valid_r;
      key_word <= key_word_r;
      disp_char <= (con_r == ctm_pkg::CON_TERMINAL) ? msg.rdata : 8'h00;
      disp_addr <= scan_d_r;
      edit_key_pulse <= key_stb && con_r == ctm_pkg::CON_EDIT &&
        sync_code1_r == ctm_pkg::KEY_EDIT;
    end
  end

  // register read port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        ctm_pkg::REG_KEY_WORD: reg_rdata <= key_word_r;
        ctm_pkg::REG_CTRL: reg_rdata <= {10'h000, msg_long_r, 2'h0, startup_r, cancel_r};
        ctm_pkg::REG_STATUS: reg_rdata <= {8'h00, mounted, msg_valid_r, exec_r,
          con_r == ctm_pkg::CON_TERMINAL, shift_r, sync_start_r[1]};
        ctm_pkg::REG_MSG_CTRL: reg_rdata <= emul_code_r;
        ctm_pkg::REG_DISP_DATA: reg_rdata <= {8'h00, msg.rdata};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule

// [ctm_console_chk.sv]
`timescale 1ns/1ns
module ctm_console_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic start_input,
  input wire logic power_restore,
  input wire logic terminal_active,
  input wire logic [2:0] exec_mode,
  input wire logic program_executing,
  input wire logic mem_write_allowed,
  input wire logic force_allowed,
  input wire logic no_message,
  input wire logic [15:0] key_word,
  input wire logic edit_key_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  prog_halts_a: assert property (
    (exec_mode == ctm_pkg::EXEC_PROGRAM && $stable(exec_mode)) |-> !program_executing)
    else $error("program mode is executing");
  run_no_write_a: assert property (
    (exec_mode == ctm_pkg::EXEC_RUN && $stable(exec_mode)) |-> !mem_write_allowed)
    else $error("run mode allows memory write");
  run_executes_a: assert property (
    (exec_mode == ctm_pkg::EXEC_RUN && $stable(exec_mode) && start_input && $past(start_input)
    && $past(start_input, 2) && $past(start_input, 3))
    |-> program_executing) else $error("run with start not executing");
  force_monitor_a: assert property (
    (exec_mode != ctm_pkg::EXEC_MONITOR && $stable(exec_mode)) |-> !force_allowed)
    else $error("forcing allowed outside monitor");
  term_holds_exec_a: assert property (
    (terminal_active && $past(terminal_active) && !$past(power_restore)) |-> $stable(exec_mode))
    else $error("selector acted in terminal state");
  term_no_edit_a: assert property (
    (terminal_active && $past(terminal_active)) |-> !edit_key_pulse)
    else $error("edit key acted in terminal state");
  key_sticky_a: assert property (
    (!$past(reg_wr) && !$past(reg_wr, 2) && !$past(reg_wr, 3) && !$past(power_restore)
    && !$past(power_restore, 2))
    |-> ((key_word & $past(key_word)) == $past(key_word))) else $error("key bit dropped");
  key_one_bit_a: assert property (
    (!$past(reg_wr) && !$past(reg_wr, 2) && !$past(power_restore) && !$past(power_restore, 2)
    && (key_word & ~$past(key_word)) != 16'h0000)
    |-> ($onehot(key_word & ~$past(key_word)) && $past(terminal_active)))
    else $error("key bits set wrongly");
  msg_stays_a: assert property (
    (!$past(no_message) && !$past(power_restore)) |-> !no_message)
    else $error("message indication came back");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read answer");
  enter_c: cover property ($rose(terminal_active));
  leave_c: cover property ($fell(terminal_active));
  key_c: cover property (terminal_active && $changed(key_word));
  run_c: cover property (program_executing && exec_mode == ctm_pkg::EXEC_RUN);
endmodule
bind ctm_console ctm_console_chk chk_u (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_input(start_input),
  .power_restore(power_restore), .terminal_active(terminal_active), .exec_mode(exec_mode),
  .program_executing(program_executing), .mem_write_allowed(mem_write_allowed),
  .force_allowed(force_allowed), .no_message(no_message), .key_word(key_word),
  .edit_key_pulse(edit_key_pulse));

// [ctm_keypad_model.sv]
`timescale 1ns/1ns
module ctm_keypad_model (
  input wire logic sys_clk,
  input wire logic press,
  input wire logic [5:0] code,
  output logic key_valid,
  output logic [5:0] key_code,
  output logic busy
);
  logic [3:0] cnt_r = 4'h0;
  logic [5:0] last_r = 6'h00;
  initial key_valid = 1'h0;
  initial key_code = 6'h3F;
  initial busy = 1'h0;
  // key held 4 cycles, then released long enough for the input synchroniser
  always @(posedge sys_clk) begin
    if (press && cnt_r == 4'h0) begin
      cnt_r <= 4'h9;
      last_r <= code;
      key_code <= code;
      key_valid <= 1'h1;
      busy <= 1'h1;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      // released pins show the inverse so a stale code never looks valid
      if (cnt_r == 4'h6) begin
        key_valid <= 1'h0;
        key_code <= ~last_r;
      end
      if (cnt_r == 4'h1) busy <= 1'h0;
    end
  end
endmodule

// [ctm_msg_if.sv]
`timescale 1ns/1ns
interface ctm_msg_if;
  logic we;
  logic [4:0] waddr;
  logic [7:0] wdata;
  logic [4:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [ctm_msg_mem.sv]
`timescale 1ns/1ns
module ctm_msg_mem #(
  parameter int DEPTH = ctm_pkg::LONG_MSG_LEN
) (
  input wire logic sys_clk,
  ctm_msg_if.mem bus
);
  logic [7:0] mem_r [DEPTH];
  logic [7:0] rdata_r;
  always_ff @(posedge sys_clk) begin
    if (bus.we) begin
      mem_r[bus.waddr] <= bus.wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    rdata_r <= mem_r[bus.raddr];
  end
  assign bus.rdata = rdata_r;
endmodule

// [ctm_pkg.sv]
package ctm_pkg;
  localparam int KEY_W = 6;
  // key codes seen on the keypad port; hex keys are 00..0F
  localparam logic [5:0] KEY_MODE_TOGGLE = 6'h21;
  localparam logic [5:0] KEY_CLEAR = 6'h20;
  localparam logic [5:0] KEY_SHIFT = 6'h22;
  localparam logic [5:0] KEY_EDIT = 6'h23;
  localparam logic [15:0] EMUL_TOGGLE_CODE = 16'h4021;
  localparam logic [7:0] EMUL_CLEAR_PAIR = 8'h40;
  localparam logic [7:0] EMUL_TOGGLE_PAIR = 8'h21;
  localparam int SHORT_MSG_LEN = 16;
  localparam int LONG_MSG_LEN = 32;
  localparam int CLEAR_PRESSES = 2;
  // register offsets
  localparam logic [3:0] REG_KEY_WORD = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_MSG_CTRL = 4'h3;
  localparam logic [3:0] REG_MSG_DATA = 4'h4;
  localparam logic [3:0] REG_DISP_DATA = 4'h5;
  // ctrl bit positions
  localparam int CTRL_CANCEL = 0;
  localparam int CTRL_STARTUP_LO = 1;
  localparam int CTRL_EMUL = 3;
  localparam int CTRL_MSG_COMMIT = 4;
  localparam int CTRL_MSG_LONG = 5;
  localparam logic [15:0] KEY_WORD_RST = 16'h0000;
  localparam logic [1:0] STARTUP_SWITCH = 2'h0;
  localparam logic [1:0] STARTUP_RESUME = 2'h1;
  localparam logic [1:0] STARTUP_TERMINAL = 2'h2;
  typedef enum logic [2:0] {
    EXEC_PROGRAM = 3'h1,
    EXEC_MONITOR = 3'h2,
    EXEC_RUN = 3'h4
  } ctm_exec_t;
  typedef enum logic [1:0] {
    CON_EDIT = 2'h1,
    CON_TERMINAL = 2'h2
  } ctm_con_t;
  typedef enum logic [2:0] {
    SCR_PASSWORD = 3'h1,
    SCR_MODE = 3'h2,
    SCR_OTHER = 3'h4
  } ctm_scr_t;
endpackage
